/* hdl/gpel_event_block.sv */
// General purpose event logic with APB registers and interrupt
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module gpel_event_block (
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Port 2 notification requests and outputs
	input  wire logic        p2_intx_req,
	input  wire logic        p2_msi_req,
	input  wire logic        p2_pme_req,
	input  wire logic        p2_hp_req,
	output logic             p2_intx_out,
	output logic             p2_msi_out,
	output logic             p2_pme_out,
	output logic             p2_hp_out,
	// Port 4 notification requests and outputs
	input  wire logic        p4_intx_req,
	input  wire logic        p4_msi_req,
	input  wire logic        p4_pme_req,
	input  wire logic        p4_hp_req,
	output logic             p4_intx_out,
	output logic             p4_msi_out,
	output logic             p4_pme_out,
	output logic             p4_hp_out,
	// General purpose pin 7 and shared event
	input  wire logic        gpio7_alt_sel,
	output logic             gpio7_out,
	output logic             gpio7_oe,
	output logic             shared_event_out,
	// Interrupt
	output logic             irq
);
	// Control fields
	logic        event_polarity_invert;
	logic        ctrl_spare;
	logic        port2_event_route_enable;
	logic        port4_event_route_enable;
	// Status flags and edge history
	logic        port2_event_flag;
	logic        port4_event_flag;
	logic        port2_flag_prev;
	logic        port4_flag_prev;
	// Interrupt registers
	logic [31:0] irq_status;
	logic [31:0] irq_mask;
	logic [31:0] next_irq_status;
	// Bus decode
	logic        access;
	logic        wr_take;
	logic        wr_byte0;
	logic        hit_ctrl;
	logic        hit_sts;
	logic        hit_isr;
	logic        hit_imr;
	logic        hit_any;
	logic [31:0] event_status;
	logic [31:0] event_control;
	logic [31:0] next_rdata;
	logic [31:0] irq_events;
	logic        any_flag;

	gpel_port_if port2_if ();
	gpel_port_if port4_if ();

	// Port 2 routing slice
	gpel_port_route u_port2 (
		.pclk    (pclk),
		.presetn (presetn),
		.prt     (port2_if.route)
	);

	// Port 4 routing slice
	gpel_port_route u_port4 (
		.pclk    (pclk),
		.presetn (presetn),
		.prt     (port4_if.route)
	);

	// Port 2 slice hookup
	assign port2_if.route_en = port2_event_route_enable;
	assign port2_if.intx_in  = p2_intx_req;
	assign port2_if.msi_in   = p2_msi_req;
	assign port2_if.pme_in   = p2_pme_req;
	assign port2_if.hp_in    = p2_hp_req;
	assign p2_intx_out       = port2_if.intx_out;
	assign p2_msi_out        = port2_if.msi_out;
	assign p2_pme_out        = port2_if.pme_out;
	assign p2_hp_out         = port2_if.hp_out;
	assign port2_event_flag  = port2_if.flag;

	// Port 4 slice hookup
	assign port4_if.route_en = port4_event_route_enable;
	assign port4_if.intx_in  = p4_intx_req;
	assign port4_if.msi_in   = p4_msi_req;
	assign port4_if.pme_in   = p4_pme_req;
	assign port4_if.hp_in    = p4_hp_req;
	assign p4_intx_out       = port4_if.intx_out;
	assign p4_msi_out        = port4_if.msi_out;
	assign p4_pme_out        = port4_if.pme_out;
	assign p4_hp_out         = port4_if.hp_out;
	assign port4_event_flag  = port4_if.flag;

	// Access phase, and write taken at the edge where pready is high
	assign access   = psel & penable;
	assign wr_take  = access & pready & pwrite;
	assign wr_byte0 = wr_take & pstrb[0];

	// Address decode
	assign hit_ctrl = (paddr == gpel_pkg::OFS_CONTROL);
	assign hit_sts  = (paddr == gpel_pkg::OFS_STATUS);
	assign hit_isr  = (paddr == gpel_pkg::OFS_IRQ_STS);
	assign hit_imr  = (paddr == gpel_pkg::OFS_IRQ_MASK);
	assign hit_any  = hit_ctrl | hit_sts | hit_isr | hit_imr;

	// Control register image, bit 3 and bits 31:5 read zero
	always_comb begin
		event_control = gpel_pkg::RST_CONTROL;
		event_control[gpel_pkg::BIT_POLARITY] = event_polarity_invert;
		event_control[gpel_pkg::BIT_SPARE]    = ctrl_spare;
		event_control[gpel_pkg::BIT_PORT2]    = port2_event_route_enable;
		event_control[gpel_pkg::BIT_PORT4]    = port4_event_route_enable;
	end

	// Status register image, all other bits read zero
	always_comb begin
		event_status = gpel_pkg::RST_STATUS;
		event_status[gpel_pkg::BIT_PORT2] = port2_event_flag;
		event_status[gpel_pkg::BIT_PORT4] = port4_event_flag;
	end

	// Control register writes; status is read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_polarity_invert    <= 1'b0;
			ctrl_spare               <= 1'b0;
			port2_event_route_enable <= 1'b0;
			port4_event_route_enable <= 1'b0;
		end else if (wr_byte0 && hit_ctrl) begin
			event_polarity_invert    <= pwdata[gpel_pkg::BIT_POLARITY];
			ctrl_spare               <= pwdata[gpel_pkg::BIT_SPARE];
			port2_event_route_enable <= pwdata[gpel_pkg::BIT_PORT2];
			port4_event_route_enable <= pwdata[gpel_pkg::BIT_PORT4];
		end
	end

	// Rising flags are the interrupt events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port2_flag_prev <= 1'b0;
			port4_flag_prev <= 1'b0;
		end else begin
			port2_flag_prev <= port2_event_flag;
			port4_flag_prev <= port4_event_flag;
		end
	end

	// Event vector in the status layout
	always_comb begin
		irq_events = gpel_pkg::RST_IRQ_STS;
		irq_events[gpel_pkg::BIT_PORT2] = port2_event_flag &
			~port2_flag_prev;
		irq_events[gpel_pkg::BIT_PORT4] = port4_event_flag &
			~port4_flag_prev;
	end

	// Sticky status, write one to clear, a new event wins over the clear
	always_comb begin
		next_irq_status = irq_status;
		if (wr_byte0 && hit_isr) begin
			next_irq_status = irq_status & ~pwdata;
		end
		next_irq_status = (next_irq_status | irq_events) &
			gpel_pkg::IRQ_BITS;
	end

	// Interrupt status register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= gpel_pkg::RST_IRQ_STS;
		end else begin
			irq_status <= next_irq_status;
		end
	end

	// Interrupt mask register, one enables the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= gpel_pkg::RST_IRQ_MASK;
		end else if (wr_byte0 && hit_imr) begin
			irq_mask <= pwdata & gpel_pkg::IRQ_BITS;
		end
	end

	// Level interrupt, from the next state so it tracks status exactly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// OR of active port flags, before polarity
	assign any_flag = port2_event_flag | port4_event_flag;

	// Shared event with polarity applied after the OR
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_event_out <= 1'b1;
		end else begin
			shared_event_out <= event_polarity_invert ? any_flag :
				~any_flag;
		end
	end

	// Pin 7 driven only in its alternate function
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio7_oe  <= 1'b0;
			gpio7_out <= 1'b1;
		end else begin
			gpio7_oe  <= gpio7_alt_sel;
			gpio7_out <= event_polarity_invert ? any_flag :
				~any_flag;
		end
	end

	// Read data for the current address
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_ctrl) begin
			next_rdata = event_control;
		end else if (hit_sts) begin
			next_rdata = event_status;
		end else if (hit_isr) begin
			next_rdata = irq_status;
		end else if (hit_imr) begin
			next_rdata = irq_mask;
		end
	end

	// One wait state: answer in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= access & ~pready;
		end
	end

	// Error answer for unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= access & ~pready & ~hit_any;
		end
	end

	// Read data captured in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (access && !pready && !pwrite) begin
			prdata <= next_rdata;
		end else if (access && pready) begin
			prdata <= 32'h0000_0000;
		end
	end
endmodule // gpel_event_block

/* hdl/gpel_pkg.sv */
// Constants, register map and field layout of the general purpose event logic
package gpel_pkg;
	localparam int         ADDR_W        = 12;
	localparam int         DATA_W        = 32;
	// Register byte offsets
	localparam logic [11:0] OFS_CONTROL  = 12'h450;
	localparam logic [11:0] OFS_STATUS   = 12'h454;
	localparam logic [11:0] OFS_IRQ_STS  = 12'h470;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h474;
	// Field positions, shared by control, status and interrupt registers
	localparam int         BIT_POLARITY  = 0;
	localparam int         BIT_SPARE     = 1;
	localparam int         BIT_PORT2     = 2;
	localparam int         BIT_PORT4     = 4;
	// Reset values
	localparam logic [31:0] RST_CONTROL  = 32'h0000_0000;
	localparam logic [31:0] RST_STATUS   = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_STS  = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
	// Bits that hold state in the interrupt registers
	localparam logic [31:0] IRQ_BITS     = 32'h0000_0014;
endpackage

/* hdl/gpel_port_if.sv */
// Signals between the event block core and one port's routing slice
`timescale 1ns/1ns
interface gpel_port_if;
	logic route_en;  // Event routing enable for this port
	logic intx_in;   // INTx assert request from the port
	logic msi_in;    // MSI request pulse from the port
	logic pme_in;    // PME request from the port
	logic hp_in;     // Hot-plug event request from the port
	logic intx_out;  // INTx request passed on
	logic msi_out;   // MSI request passed on
	logic pme_out;   // PME request passed on
	logic hp_out;    // Hot-plug request passed on
	logic flag;      // Port is signalling on the shared event

	modport core (
		output route_en, intx_in, msi_in, pme_in, hp_in,
		input  intx_out, msi_out, pme_out, hp_out, flag
	);
	modport route (
		input  route_en, intx_in, msi_in, pme_in, hp_in,
		output intx_out, msi_out, pme_out, hp_out, flag
	);
endinterface

/* hdl/gpel_port_route.sv */
// One port's notification routing slice
`timescale 1ns/1ns
module gpel_port_route (
	input  wire logic   pclk,
	input  wire logic   presetn,
	gpel_port_if.route  prt
);
	logic any_req;

	// Any pending or requested notification from the port
	assign any_req = prt.intx_in | prt.msi_in | prt.pme_in | prt.hp_in;

	// Normal notices pass only while routing is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prt.intx_out <= 1'b0;
			prt.msi_out  <= 1'b0;
			prt.pme_out  <= 1'b0;
			prt.hp_out   <= 1'b0;
		end else begin
			prt.intx_out <= prt.intx_in & ~prt.route_en;
			prt.msi_out  <= prt.msi_in & ~prt.route_en;
			prt.pme_out  <= prt.pme_in & ~prt.route_en;
			prt.hp_out   <= prt.hp_in & ~prt.route_en;
		end
	end

	// Event flag follows requests only while routing is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prt.flag <= 1'b0;
		end else begin
			prt.flag <= prt.route_en & any_req;
		end
	end
endmodule // gpel_port_route

/* dv/gpel_asserts.sv */
// Port-level assertion checker for the event block
`timescale 1ns/1ns
module gpel_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        p2_hp_req,
	input wire logic        p2_hp_out,
	input wire logic        p4_intx_req,
	input wire logic        p4_intx_out,
	input wire logic        gpio7_alt_sel,
	input wire logic        gpio7_oe,
	input wire logic        gpio7_out,
	input wire logic        shared_event_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus phases
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	// One wait state, then a single answer cycle
	AST_ONE_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("answer not after one wait state");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	// Port 2 hot-plug and port 4 INTx notices pass only when requested a cycle before; pin 7 follows its select and the shared event
	AST_P2_PASS: assert property (p2_hp_out |-> $past(p2_hp_req))
		else $error("port 2 notice without request");
	AST_P4_PASS: assert property (p4_intx_out |-> $past(p4_intx_req))
		else $error("port 4 notice without request");
	AST_PIN_OE: assert property ($past(presetn) |-> gpio7_oe == $past(gpio7_alt_sel))
		else $error("pin enable not following alternate select");
	AST_PIN_LEVEL: assert property (gpio7_out == shared_event_out)
		else $error("pin level differs from shared event");
endmodule // gpel_asserts

bind gpel_event_block gpel_asserts u_chk (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
	.p2_hp_req, .p2_hp_out, .p4_intx_req, .p4_intx_out,
	.gpio7_alt_sel, .gpio7_oe, .gpio7_out, .shared_event_out
);

/* dv/gpel_chipset_model.sv */
// Chipset event input watching the shared event pin
`timescale 1ns/1ns
module gpel_chipset_model (
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic active_high,
	output logic     event_seen
);
	logic pin_level;
	// Board pull-up holds the line high while undriven
	assign pin_level = pin_oe ? pin_out : 1'h1;
	// Event seen while the line sits at its active level
	assign event_seen = (pin_level == active_high);
endmodule // gpel_chipset_model

/* dv/testbench.sv */
// Self-checking bench for the event block
`timescale 1ns/1ns
module testbench;
	typedef struct {
		logic [31:0] ctl;
		logic [3:0]  q2;
		logic [3:0]  q4;
		logic        al;
		logic [31:0] sts;
		logic        ev;
	} gpel_row_t;
	logic        pclk, presetn, psel, penable, pwrite, alt, pol;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er, seen, ev_out, g_out, g_oe, irq;
	logic [3:0]  r2, r4, o2, o4, strb;
	int          num_errors, cmp_count;
	gpel_row_t   rows [6] = '{
		'{32'h0, 4'h1, 4'h1, 1'h1, 32'h0, 1'h1},
		'{32'h4, 4'h2, 4'h0, 1'h1, 32'h4, 1'h0},
		'{32'h14, 4'h0, 4'h4, 1'h0, 32'h10, 1'h0},
		'{32'h15, 4'h8, 4'h8, 1'h1, 32'h14, 1'h1},
		'{32'h11, 4'hF, 4'h0, 1'h0, 32'h0, 1'h0},
		'{32'h3, 4'h0, 4'h0, 1'h1, 32'h0, 1'h0}};
	logic [11:0] adr [4] = '{gpel_pkg::OFS_CONTROL, gpel_pkg::OFS_STATUS,
		gpel_pkg::OFS_IRQ_STS, gpel_pkg::OFS_IRQ_MASK};

	gpel_event_block DUT (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.p2_intx_req(r2[0]), .p2_msi_req(r2[1]), .p2_pme_req(r2[2]),
		.p2_hp_req(r2[3]), .p2_intx_out(o2[0]), .p2_msi_out(o2[1]),
		.p2_pme_out(o2[2]), .p2_hp_out(o2[3]),
		.p4_intx_req(r4[0]), .p4_msi_req(r4[1]), .p4_pme_req(r4[2]),
		.p4_hp_req(r4[3]), .p4_intx_out(o4[0]), .p4_msi_out(o4[1]),
		.p4_pme_out(o4[2]), .p4_hp_out(o4[3]), .gpio7_alt_sel(alt),
		.gpio7_out(g_out), .gpio7_oe(g_oe), .shared_event_out(ev_out),
		.irq(irq));
	gpel_chipset_model u_cs (.pin_out(g_out), .pin_oe(g_oe),
		.active_high(pol), .event_seen(seen));

	// Clock
	always #25 pclk = ~pclk;

	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask

	// One bus transfer; result lands in rd and er
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Verdict
	task test_done;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		$display("ERROR %0t watchdog expired", $time);
		test_done;
	end

	// Main sequence
	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		{psel, penable, pwrite, alt, pol} = 5'h0;
		{paddr, pwdata, r2, r4} = 52'h0;
		strb = 4'hF;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, adr[i], 32'h0);
			chk(rd, 32'h0);
		end
		$display("reset values test done");
		foreach (rows[i]) begin
			apb(1'h1, gpel_pkg::OFS_CONTROL, rows[i].ctl);
			@(posedge pclk);
			r2 <= rows[i].q2;
			r4 <= rows[i].q4;
			alt <= rows[i].al;
			pol <= rows[i].ctl[0];
			repeat (4) @(posedge pclk);
			chk(ev_out, rows[i].ev);
			chk(g_out, rows[i].ev);
			chk(g_oe, rows[i].al);
			chk(o2, rows[i].ctl[2] ? 4'h0 : rows[i].q2);
			chk(o4, rows[i].ctl[4] ? 4'h0 : rows[i].q4);
			chk(seen, (rows[i].al ? rows[i].ev : 1'h1) == pol);
			apb(1'h0, gpel_pkg::OFS_STATUS, 32'h0);
			chk(rd, rows[i].sts);
			apb(1'h0, gpel_pkg::OFS_CONTROL, 32'h0);
			chk(rd, rows[i].ctl);
		end
		$display("table test done");
		apb(1'h1, 12'h458, 32'hFF);
		chk(er, 1'h1);
		apb(1'h1, gpel_pkg::OFS_STATUS, 32'h14);
		apb(1'h0, gpel_pkg::OFS_STATUS, 32'h0);
		chk(er, 1'h0);
		chk(rd, 32'h0);
		// Write with byte 0 strobe low must leave control alone
		strb <= 4'hE;
		apb(1'h1, gpel_pkg::OFS_CONTROL, 32'h15);
		strb <= 4'hF;
		apb(1'h0, gpel_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h3);
		$display("refusal test done");
		apb(1'h1, gpel_pkg::OFS_IRQ_STS, 32'h14);
		apb(1'h1, gpel_pkg::OFS_IRQ_MASK, 32'h14);
		apb(1'h1, gpel_pkg::OFS_CONTROL, 32'h10);
		r4 <= 4'h2;
		repeat (4) @(posedge pclk);
		chk(irq, 1'h1);
		apb(1'h0, gpel_pkg::OFS_IRQ_STS, 32'h0);
		chk(rd, 32'h10);
		apb(1'h1, gpel_pkg::OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 1'h0);
		r4 <= 4'h0;
		apb(1'h1, gpel_pkg::OFS_IRQ_STS, 32'h14);
		apb(1'h0, gpel_pkg::OFS_IRQ_STS, 32'h0);
		chk(rd, 32'h0);
		$display("interrupt test done");
		apb(1'h1, gpel_pkg::OFS_CONTROL, 32'h15);
		apb(1'h0, gpel_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h15);
		chk(ev_out, 1'h0);
		presetn <= 1'h0;
		@(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, gpel_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h0);
		chk(ev_out, 1'h1);
		$display("mid-run reset test done");
		test_done;
	end
endmodule // testbench
